/* File: rtl/syscmd_core.sv */
// System command interpreter core with Wishbone register slave
`include "syscmd_cfg.svh"
module syscmd_core
    import syscmd_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    // Wishbone slave
    input  wire wb_req_t  wb_i,
    output wb_rsp_t       wb_o,
    // Instrument state inputs
    input  wire logic     sig_ch1_i,
    input  wire logic     sig_ch2_i,
    input  wire logic     acq_running_i,
    input  wire logic     err_valid_i,
    input  wire logic [15:0] err_code_i,
    // Reply options and bus actions
    output logic          eoi_en_o,
    output logic          hdr_en_o,
    output logic          alpha_args_o,
    output logic          bus_clear_o,
    output logic [7:0]    status_byte_o,
    // Front panel and acquisition actions
    output logic          key_press_o,
    output logic [5:0]    key_code_o,
    output capture_t      capture_o,
    output erase_t        erase_o,
    output blank_t        blank_o,
    output auto_t         auto_o
);
    localparam int CAL_W = `CAL_BYTES / 4;
    localparam int ADV_W = `ADV_CHARS / 4;

    logic [15:0]             err_mem_q [`ERR_DEPTH];
    logic [`ERR_PTR_W-1:0]   err_wr_q;
    logic [`ERR_PTR_W-1:0]   err_rd_q;
    logic [`ERR_CNT_W-1:0]   err_cnt_q;
    logic [2:0]              opts_q;
    logic [5:0]              key_q;
    logic [31:0]             cal_q [CAL_W];
    logic [31:0]             cal_save_q [CAL_W];
    logic [31:0]             adv_q [ADV_W];
    logic [31:0]             arg_q;
    logic                    err_flag_q;
    logic                    ack_q;
    logic [31:0]             rdat_q;
    logic                    eoi_q;
    logic                    hdr_q;
    logic                    alpha_q;
    logic                    clear_q;
    logic                    key_press_q;
    capture_t                capture_q;
    erase_t                  erase_q;
    blank_t                  blank_q;
    auto_t                   auto_q;
    erase_st_t               er_st_q;

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] plane_map(input logic [1:0] plane);
        return (plane == 2'd1) ? `PLANE1_PIXMEM : `PLANE2_PIXMEM;
    endfunction

    wire logic req      = wb_i.cyc & wb_i.stb & ~ack_q;
    wire logic wr       = req & wb_i.we;
    wire logic rd       = req & ~wb_i.we;
    wire logic cmd_wr   = wr & (wb_i.adr == `ADR_CMD);
    wire cmd_t cmd      = cmd_t'(wb_i.dat[3:0]);
    wire logic do_clear = cmd_wr & (cmd == CMD_CLEAR);
    wire logic err_pop  = rd & (wb_i.adr == `ADR_ERR) & (err_cnt_q != '0);
    wire logic sw_err   = wr & (wb_i.adr == `ADR_ERR_PUSH);
    wire logic bad_cmd  = cmd_wr & (wb_i.dat[3:0] > 4'(CMD_SELFTEST));
    wire logic bad_key  = cmd_wr & (cmd == CMD_KEY) & (arg_q[5:0] == `KEY_NONE);
    wire logic push_v   = err_valid_i | sw_err | bad_cmd | bad_key;
    wire logic [15:0] push_code = err_valid_i ? err_code_i :
                                  sw_err      ? wb_i.dat[15:0] :
                                  bad_cmd     ? `ERR_UNKNOWN : `ERR_RANGE;
    wire logic full     = (err_cnt_q == 5'(`ERR_DEPTH));
    wire logic push     = push_v & ~full & ~do_clear;

    // Bus handshake, ack registered one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Error FIFO, clear-over-push, push and pop by independent pointers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_wr_q  <= '0;
            err_rd_q  <= '0;
            err_cnt_q <= '0;
        end else if (do_clear) begin
            err_wr_q  <= '0;
            err_rd_q  <= '0;
            err_cnt_q <= '0;
        end else begin
            if (push) begin
                err_mem_q[err_wr_q] <= push_code;
                err_wr_q            <= err_wr_q + 1'b1;
            end
            if (err_pop) begin
                err_rd_q <= err_rd_q + 1'b1;
            end
            err_cnt_q <= err_cnt_q + 5'(push) - 5'(err_pop);
        end
    end

    // Error flag in the status byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_flag_q <= 1'b0;
        end else if (push_v) begin
            err_flag_q <= 1'b1;
        end else if (do_clear) begin
            err_flag_q <= 1'b0;
        end else if (err_pop && err_cnt_q == 5'd1) begin
            err_flag_q <= 1'b0;
        end
    end

    // Reply options and argument register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opts_q <= `OPTS_RESET;
            arg_q  <= '0;
        end else begin
            if (wr && wb_i.adr == `ADR_OPTS) begin
                opts_q <= 3'(lane_merge(32'(opts_q), wb_i.dat, wb_i.sel));
            end
            if (wr && wb_i.adr == `ADR_ARG) begin
                arg_q <= lane_merge(arg_q, wb_i.dat, wb_i.sel);
            end
        end
    end

    // Key register and key press pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_q       <= `KEY_NONE;
            key_press_q <= 1'b0;
        end else begin
            key_press_q <= 1'b0;
            if (do_clear) begin
                key_q <= `KEY_NONE;
            end else if (cmd_wr && cmd == CMD_KEY && arg_q[5:0] != `KEY_NONE) begin
                key_q       <= arg_q[5:0];
                key_press_q <= 1'b1;
            end
        end
    end

    // Calibration string and its saved copy
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CAL_W; i++) begin
            if (rst_i) begin
                cal_q[i]      <= '0;
                cal_save_q[i] <= '0;
            end else if (cmd_wr && cmd == CMD_SAVE) begin
                cal_save_q[i] <= cal_q[i];
            end else if (cmd_wr && cmd == CMD_RECALL) begin
                cal_q[i] <= cal_save_q[i];
            end else if (wr && wb_i.adr == 8'(`ADR_CAL_BASE + 4 * i)) begin
                cal_q[i] <= lane_merge(cal_q[i], wb_i.dat, wb_i.sel);
            end
        end
    end

    // Advisory line text
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < ADV_W; i++) begin
            if (rst_i) begin
                adv_q[i] <= '0;
            end else if (wr && wb_i.adr == 8'(`ADR_ADV_BASE + 4 * i)) begin
                adv_q[i] <= lane_merge(adv_q[i], wb_i.dat, wb_i.sel);
            end
        end
    end

    // Read data mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (rd) begin
            rdat_q <= '0;
            if (wb_i.adr == `ADR_ARG) begin
                rdat_q <= arg_q;
            end else if (wb_i.adr == `ADR_OPTS) begin
                rdat_q <= {29'h0, opts_q};
            end else if (wb_i.adr == `ADR_ERR) begin
                rdat_q <= (err_cnt_q == '0) ? 32'(`ERR_NONE) :
                          {{16{err_mem_q[err_rd_q][15]}}, err_mem_q[err_rd_q]};
            end else if (wb_i.adr == `ADR_STATUS) begin
                rdat_q <= {24'h0, status_byte_o};
            end else if (wb_i.adr == `ADR_KEY) begin
                rdat_q <= {26'h0, key_q};
            end else if (wb_i.adr == `ADR_MODEL) begin
                rdat_q <= `MODEL_ID;
            end else if (wb_i.adr >= `ADR_CAL_BASE && wb_i.adr <= `ADR_CAL_LAST) begin
                rdat_q <= (wb_i.adr[6:2] - 5'd8 < 5'(CAL_W)) ? cal_q[3'(wb_i.adr[6:2] - 5'd8)] : '0;
            end else if (wb_i.adr >= `ADR_ADV_BASE) begin
                rdat_q <= (wb_i.adr[6:2] < 5'(ADV_W)) ? adv_q[3'(wb_i.adr[6:2])] : '0;
            end
        end
    end

    // Capture, blanking and auto-setup actions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_q <= '0;
            blank_q   <= '0;
            auto_q    <= '0;
            clear_q   <= 1'b0;
        end else begin
            capture_q.valid <= 1'b0;
            blank_q.valid   <= 1'b0;
            auto_q.valid    <= 1'b0;
            clear_q         <= do_clear;
            if (cmd_wr && cmd == CMD_CAPTURE) begin
                capture_q.valid    <= 1'b1;
                capture_q.chan     <= arg_q[1:0];
                capture_q.min_max  <= arg_q[4];
                capture_q.mem_mask <= arg_q[4] ? {arg_q[1:0], arg_q[1:0]} : {2'b00, arg_q[1:0]};
            end
            if (cmd_wr && cmd == CMD_BLANK) begin
                blank_q.valid <= 1'b1;
                blank_q.kind  <= arg_q[6:4];
                blank_q.index <= (arg_q[6:4] == 3'd2) ? plane_map(arg_q[1:0]) : arg_q[2:0];
            end
            if (cmd_wr && cmd == CMD_AUTO) begin
                auto_q.valid          <= 1'b1;
                auto_q.trig_chan1     <= sig_ch1_i | ~sig_ch2_i;
                auto_q.split_screen   <= sig_ch1_i & sig_ch2_i;
                auto_q.menu_timebase  <= 1'b1;
                auto_q.assign_sec_div <= 1'b1;
                auto_q.remote_listen  <= 1'b1;
            end
        end
    end

    // Plane erase, with pause and resume for plane 0 during acquisition
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            erase_q <= '0;
            er_st_q <= ST_IDLE;
        end else begin
            erase_q.valid <= 1'b0;
            case (er_st_q)
                ST_IDLE: begin
                    if (cmd_wr && cmd == CMD_ERASE) begin
                        erase_q.valid         <= 1'b1;
                        erase_q.clear_display <= (arg_q[1:0] == 2'd0);
                        erase_q.pixmem        <= (arg_q[1:0] == 2'd0) ? 3'h0 : plane_map(arg_q[1:0]);
                        if (arg_q[1:0] == 2'd0 && acq_running_i) begin
                            erase_q.pause_acq <= 1'b1;
                            er_st_q           <= ST_PAUSE;
                        end
                    end
                end
                ST_PAUSE: begin
                    er_st_q <= ST_RESUME;
                end
                ST_RESUME: begin
                    erase_q.pause_acq <= 1'b0;
                    er_st_q           <= ST_IDLE;
                end
                default: begin
                    er_st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eoi_q   <= 1'b1;
            hdr_q   <= 1'b0;
            alpha_q <= 1'b0;
        end else begin
            eoi_q   <= opts_q[`OPT_EOI_BIT];
            hdr_q   <= opts_q[`OPT_HDR_BIT];
            alpha_q <= opts_q[`OPT_ALPHA_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_byte_o <= '0;
        end else begin
            status_byte_o <= 8'(err_flag_q) << `STB_ERR_BIT;
        end
    end

    assign wb_o.ack     = ack_q;
    assign wb_o.dat     = rdat_q;
    assign eoi_en_o     = eoi_q;
    assign hdr_en_o     = hdr_q;
    assign alpha_args_o = alpha_q;
    assign bus_clear_o  = clear_q;
    assign key_press_o  = key_press_q;
    assign key_code_o   = key_q;
    assign capture_o    = capture_q;
    assign erase_o      = erase_q;
    assign blank_o      = blank_q;
    assign auto_o       = auto_q;
endmodule

/* File: include/syscmd_cfg.svh */
// Offsets, field positions, reset values and codes for the system command block
`ifndef SYSCMD_CFG_SVH
`define SYSCMD_CFG_SVH
`define ADR_CMD        8'h00
`define ADR_ARG        8'h04
`define ADR_OPTS       8'h08
`define ADR_ERR        8'h0c
`define ADR_STATUS     8'h10
`define ADR_KEY        8'h14
`define ADR_CAL_BASE   8'h20
`define ADR_CAL_LAST   8'h7c
`define ADR_ADV_BASE   8'h80
`define ADR_ADV_LAST   8'hfc
`define ADR_ERR_PUSH   8'h18
`define ADR_MODEL      8'h1c
`define OPT_EOI_BIT    0
`define OPT_HDR_BIT    1
`define OPT_ALPHA_BIT  2
`define OPTS_RESET     3'h1
`define ERR_DEPTH      16
`define ERR_PTR_W      4
`define ERR_CNT_W      5
`define ERR_NONE       16'h0000
`define ERR_UNKNOWN    16'hff9c
`define ERR_RANGE      16'hff2c
`define ERR_OVERFLOW   16'hff19
`define ERR_SELFTEST   16'hfeac
`define STB_ERR_BIT    5
`define KEY_NONE       6'h00
`define KEY_MAX        6'h3f
`define CAL_BYTES      24
`define ADV_CHARS      32
`define PLANE1_PIXMEM  3'h5
`define PLANE2_PIXMEM  3'h6
`define MODEL_ID       32'h0000_1234 // Arbitrary value
`endif

/* File: include/syscmd_pkg.sv */
// Types for the system command block
package syscmd_pkg;
    typedef enum logic [3:0] {
        CMD_NOP, CMD_CLEAR, CMD_KEY, CMD_CAPTURE, CMD_ERASE, CMD_BLANK,
        CMD_AUTO, CMD_SAVE, CMD_RECALL, CMD_SELFTEST
    } cmd_t;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;
    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        logic       min_max;
        logic [3:0] mem_mask;
    } capture_t;
    typedef struct packed {
        logic       valid;
        logic [2:0] pixmem;
        logic       clear_display;
        logic       pause_acq;
    } erase_t;
    typedef struct packed {
        logic       valid;
        logic [2:0] kind;
        logic [2:0] index;
    } blank_t;
    typedef struct packed {
        logic       valid;
        logic       trig_chan1;
        logic       split_screen;
        logic       menu_timebase;
        logic       assign_sec_div;
        logic       remote_listen;
    } auto_t;
    typedef enum logic [1:0] {
        ST_IDLE, ST_PAUSE, ST_RESUME
    } erase_st_t;
endpackage

/* File: tb/syscmd_assertions.sv */
// Port-level assertions for the system command block
`include "syscmd_cfg.svh"
module syscmd_checker
    import syscmd_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus
    input wire wb_req_t     wb_i,
    input wire wb_rsp_t     wb_o,
    // Instrument inputs
    input wire logic        sig_ch1_i,
    input wire logic        sig_ch2_i,
    input wire logic        acq_running_i,
    input wire logic        err_valid_i,
    input wire logic [15:0] err_code_i,
    // Design outputs
    input wire logic        eoi_en_o,
    input wire logic        hdr_en_o,
    input wire logic        alpha_args_o,
    input wire logic        bus_clear_o,
    input wire logic [7:0]  status_byte_o,
    input wire logic        key_press_o,
    input wire logic [5:0]  key_code_o,
    input wire capture_t    capture_o,
    input wire erase_t      erase_o,
    input wire blank_t      blank_o,
    input wire auto_t       auto_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        take;
    logic        clr;
    logic [31:0] arg_q;
    assign take = wb_i.cyc && wb_i.stb && !wb_o.ack;
    assign clr = take && wb_i.we && wb_i.adr == `ADR_CMD && wb_i.dat[3:0] == CMD_CLEAR;
    // Argument word seen by the block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arg_q <= '0;
        end else if (take && wb_i.we && wb_i.adr == `ADR_ARG) begin
            arg_q <= wb_i.dat;
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wr(logic [7:0] a);
        take && wb_i.we && wb_i.adr == a;
    endsequence
    sequence s_cmd(logic [3:0] c);
        s_wr(`ADR_CMD) ##0 wb_i.dat[3:0] == c;
    endsequence
    opts_write_a: assert property (s_wr(`ADR_OPTS) |-> ##2
        {alpha_args_o, hdr_en_o, eoi_en_o} == $past(wb_i.dat[2:0], 2)) else $error("option outputs wrong");
    bus_clear_a: assert property (s_cmd(CMD_CLEAR) |=> bus_clear_o ##1 !bus_clear_o)
        else $error("clear pulse wrong");
    clear_key_a: assert property (s_cmd(CMD_CLEAR) |-> ##2 key_code_o == `KEY_NONE)
        else $error("key not cleared");
    err_flag_a: assert property (err_valid_i && !clr && !bus_clear_o |-> ##2 status_byte_o[`STB_ERR_BIT])
        else $error("error flag not set");
    status_bits_a: assert property ((status_byte_o & 8'hdf) == 8'h00)
        else $error("stray status bits");
    key_press_a: assert property (s_cmd(CMD_KEY) ##0 arg_q[5:0] != 6'h00 |=>
        key_press_o ##1 key_code_o == arg_q[5:0]) else $error("key press wrong");
    key_refuse_a: assert property (s_cmd(CMD_KEY) ##0 arg_q[5:0] == 6'h00 |=> !key_press_o)
        else $error("key zero pressed");
    erase_map_a: assert property (s_cmd(CMD_ERASE) ##0 (arg_q[1] ^ arg_q[0]) |=> erase_o.valid &&
        erase_o.pixmem == (arg_q[0] ? `PLANE1_PIXMEM : `PLANE2_PIXMEM)) else $error("erase map wrong");
    erase_pause_a: assert property (s_cmd(CMD_ERASE) ##0 (arg_q[1:0] == 2'h0 && acq_running_i) |=>
        erase_o.clear_display && erase_o.pause_acq ##1 erase_o.pause_acq ##1 !erase_o.pause_acq)
        else $error("erase pause wrong");
    blank_map_a: assert property (s_cmd(CMD_BLANK) ##0 (arg_q[6:4] == 3'h2 && (arg_q[1] ^ arg_q[0])) |=>
        blank_o.valid && blank_o.index == (arg_q[0] ? `PLANE1_PIXMEM : `PLANE2_PIXMEM)) else $error("blank wrong");
    capture_mask_a: assert property (s_cmd(CMD_CAPTURE) |=> capture_o.valid && capture_o.mem_mask ==
        {arg_q[1] & arg_q[4], arg_q[0] & arg_q[4], arg_q[1], arg_q[0]}) else $error("capture mask wrong");
    auto_setup_a: assert property (s_cmd(CMD_AUTO) |=> auto_o.valid && auto_o.menu_timebase &&
        auto_o.assign_sec_div && auto_o.remote_listen && auto_o.split_screen == $past(sig_ch1_i && sig_ch2_i))
        else $error("auto setup wrong");
    model_id_a: assert property (take && !wb_i.we && wb_i.adr == `ADR_MODEL |=> wb_o.dat == `MODEL_ID)
        else $error("model id wrong");
endmodule

/* File: tb/host_model.sv */
// Bus controller model issuing classic Wishbone single cycles
`include "syscmd_cfg.svh"
module host_model
    import syscmd_pkg::*;
(
    // Clock
    input  wire logic    clk_i,
    // Wishbone master side
    output wb_req_t      req_o,
    input  wire wb_rsp_t rsp_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        req_o <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
        do @(posedge clk_i); while (rsp_i.ack !== 1'b1);
        r = rsp_i.dat;
        req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~w, sel: 4'h0, adr: ~a, dat: ~d};
        @(posedge clk_i);
        repeat ($urandom_range(0, 1)) @(posedge clk_i);
    endtask
    // Reads the calibration words and returns them untouched
    task automatic cal_echo();
        logic [31:0] s[6];
        logic [31:0] u;
        for (int i = 0; i < 6; i++) xfer(1'b0, `ADR_CAL_BASE + 8'(4 * i), 32'h0, s[i]);
        for (int i = 0; i < 6; i++) xfer(1'b1, `ADR_CAL_BASE + 8'(4 * i), s[i], u);
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the system command block
`include "syscmd_cfg.svh"
module tb_top
    import syscmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wb_req_t     wb_i;
    wb_rsp_t     wb_o;
    logic        sig_ch1_i = 1'b0;
    logic        sig_ch2_i = 1'b0;
    logic        acq_running_i = 1'b0;
    logic        err_valid_i = 1'b0;
    logic [15:0] err_code_i = 16'h0000;
    logic        eoi_en_o, hdr_en_o, alpha_args_o, bus_clear_o, key_press_o;
    logic [7:0]  status_byte_o;
    logic [5:0]  key_code_o;
    capture_t    capture_o;
    erase_t      erase_o;
    blank_t      blank_o;
    auto_t       auto_o;
    logic [31:0] exp_q[$];
    logic [31:0] q;
    logic [31:0] v[8];
    logic [15:0] e[16];
    logic [5:0]  keys[4] = '{6'h01, 6'h30, 6'h3f, 6'h28};
    int          n_fail = 0;
    int          n_checks = 0;
    int          cycles = 0;
    syscmd_core i_syscmd_core (.clk_i, .rst_i, .wb_i, .wb_o, .sig_ch1_i, .sig_ch2_i, .acq_running_i,
        .err_valid_i, .err_code_i, .eoi_en_o, .hdr_en_o, .alpha_args_o, .bus_clear_o, .status_byte_o,
        .key_press_o, .key_code_o, .capture_o, .erase_o, .blank_o, .auto_o);
    host_model i_host_model (.clk_i, .req_o(wb_i), .rsp_i(wb_o));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic note(input string s);
        $display("test %s finished", s);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host_model.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        i_host_model.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic cmd(input cmd_t c, input logic [31:0] arg);
        wr(`ADR_ARG, arg);
        wr(`ADR_CMD, {28'h0, c});
    endtask
    task automatic push_err(input logic [15:0] c);
        err_code_i <= c;
        err_valid_i <= 1'b1;
        @(posedge clk_i);
        err_valid_i <= 1'b0;
        err_code_i <= ~c;
    endtask
    task automatic blk(input logic [7:0] b, input int n, input logic w, input logic [31:0] x);
        for (int i = 0; i < n; i++) begin
            if (w) begin
                wr(b + 8'(4 * i), v[i] ^ x);
            end else begin
                rd(b + 8'(4 * i), v[i] ^ x);
            end
        end
    endtask
    // Read data checker and hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (wb_o.ack === 1'b1 && wb_i.we === 1'b0 && exp_q.size() > 0) begin
            check(wb_o.dat, exp_q.pop_front());
        end
        if (cycles == 8000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        q = $urandom(38218);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({31'h0, eoi_en_o}, 32'h1);
        check({31'h0, hdr_en_o}, 32'h0);
        rd(`ADR_KEY, 32'h0);
        rd(`ADR_ERR, 32'h0);
        rd(`ADR_MODEL, `MODEL_ID);
        note("reset");
        for (int i = 0; i < 8; i++) begin
            wr(`ADR_OPTS, i);
            check({29'h0, alpha_args_o, hdr_en_o, eoi_en_o}, i);
            rd(`ADR_OPTS, i);
        end
        wr(`ADR_OPTS, 32'h1);
        note("options");
        wr(`ADR_CMD, 32'h9);
        wr(`ADR_CMD, 32'hf);
        e[0] = `ERR_UNKNOWN;
        push_err(`ERR_SELFTEST);
        e[1] = `ERR_SELFTEST;
        for (int i = 2; i < 17; i++) begin
            q[15:0] = 16'($urandom_range(1, 200));
            if (i < 16) e[i] = q[15:0];
            if (i[0]) push_err(q[15:0]);
            else wr(`ADR_ERR_PUSH, {16'h0, q[15:0]});
        end
        check({24'h0, status_byte_o}, 32'h20);
        for (int i = 0; i < 16; i++) rd(`ADR_ERR, {{16{e[i][15]}}, e[i]});
        rd(`ADR_ERR, 32'h0);
        rd(`ADR_ERR, 32'h0);
        check({24'h0, status_byte_o}, 32'h0);
        note("errors");
        for (int i = 0; i < 4; i++) begin
            cmd(CMD_KEY, keys[i]);
            rd(`ADR_KEY, keys[i]);
        end
        cmd(CMD_KEY, 32'h0);
        rd(`ADR_ERR, {16'hffff, `ERR_RANGE});
        push_err(`ERR_OVERFLOW);
        cmd(CMD_CLEAR, 32'h0);
        rd(`ADR_KEY, 32'h0);
        rd(`ADR_ERR, 32'h0);
        check({24'h0, status_byte_o}, 32'h0);
        note("keys and clear");
        for (int i = 0; i < 8; i++) v[i] = $urandom;
        blk(`ADR_CAL_BASE, 6, 1'b1, 32'h0);
        blk(`ADR_CAL_BASE, 6, 1'b0, 32'h0);
        cmd(CMD_SAVE, 32'h0);
        blk(`ADR_CAL_BASE, 6, 1'b1, 32'hffffffff);
        cmd(CMD_RECALL, 32'h0);
        blk(`ADR_CAL_BASE, 6, 1'b0, 32'h0);
        for (int i = 0; i < 6; i++) exp_q.push_back(v[i]);
        i_host_model.cal_echo();
        blk(`ADR_CAL_BASE, 6, 1'b0, 32'h0);
        blk(`ADR_ADV_BASE, 8, 1'b1, 32'h0);
        blk(`ADR_ADV_BASE, 8, 1'b0, 32'h0);
        note("calibration and text");
        acq_running_i <= 1'b1;
        for (int i = 0; i < 8; i++) cmd(CMD_CAPTURE, {27'h0, i[2], 2'h0, 2'($urandom_range(1, 3))});
        for (int i = 0; i < 3; i++) cmd(CMD_ERASE, i);
        cmd(CMD_BLANK, 32'h21);
        cmd(CMD_BLANK, 32'h22);
        for (int i = 0; i < 4; i++) begin
            sig_ch1_i <= i[0];
            sig_ch2_i <= i[1];
            cmd(CMD_AUTO, 32'h0);
        end
        note("actions");
        results();
    end
endmodule
bind syscmd_core syscmd_checker i_syscmd_checker (.clk_i, .rst_i, .wb_i, .wb_o, .sig_ch1_i, .sig_ch2_i,
    .acq_running_i, .err_valid_i, .err_code_i, .eoi_en_o, .hdr_en_o, .alpha_args_o, .bus_clear_o,
    .status_byte_o, .key_press_o, .key_code_o, .capture_o, .erase_o, .blank_o, .auto_o);
